//--- design/dmab_regs.vh
// Constants for the two-channel DMA count engine and its bus arbiter.
// Included by the top module and the arbiter; it holds definitions only.
// Notes on behaviour
// - Two independent channels, each moving byte, word, longword or 16-byte line operands.
// - Off-chip moves are single or dual address; on-chip moves are dual only.
// - Each channel holds a 32-bit destination, used only for dual-address moves.
// - Each channel keeps a 16-bit count of block bytes still to be written.
// - Count drops after a write address phase (dual) or any phase (single).
// - The drop equals the size: 1 byte, 2 word, 4 longword, 16 line.
// - The done flag sets when the count reaches zero.
// - A start with a count misaligned to the size flags an error, moves nothing.
// - Arbiter-off bit at one stops arbitration; at zero it runs.
// - With arbitration off the channels never get the bus.
// - Priority bit zero favours the core; one favours the channels.
// - A killed core fetch lowers core priority for the next bus cycle.
`ifndef DMAB_REGS_VH
`define DMAB_REGS_VH

// Register byte addresses; channel 1 sits one stride above channel 0.
`define DMAB_CH_STRIDE   8'h10
`define DMAB_OFF_CTRL    8'h00
`define DMAB_OFF_DEST    8'h04
`define DMAB_OFF_COUNT   8'h08
`define DMAB_OFF_CHSTAT  8'h0c
`define DMAB_OFF_ARB     8'h20
`define DMAB_OFF_IMASK   8'h24
`define DMAB_OFF_ISTAT   8'h28

// Control register fields.
`define DMAB_CTRL_START  0
`define DMAB_CTRL_SIZE_L 1
`define DMAB_CTRL_SIZE_H 2
`define DMAB_CTRL_SINGLE 3
`define DMAB_CTRL_OFFCHIP 4

// Channel status fields.
`define DMAB_CHST_DONE   0
`define DMAB_CHST_ERR    1
`define DMAB_CHST_BUSY   2

// Arbiter control fields.
`define DMAB_ARB_OFF     0
`define DMAB_ARB_PRIO    1

// Transfer size encodings.
`define DMAB_SZ_LONG     2'h0
`define DMAB_SZ_BYTE     2'h1
`define DMAB_SZ_WORD     2'h2
`define DMAB_SZ_LINE     2'h3

// Count decrements per size.
`define DMAB_DEC_BYTE    16'h0001
`define DMAB_DEC_WORD    16'h0002
`define DMAB_DEC_LONG    16'h0004
`define DMAB_DEC_LINE    16'h0010

// Low-bit masks that must be clear for an aligned count.
`define DMAB_ALN_WORD    16'h0001
`define DMAB_ALN_LONG    16'h0003
`define DMAB_ALN_LINE    16'h000f

// Reset values.
`define DMAB_RST_DEST    32'h00000000
`define DMAB_RST_COUNT   16'h0000
`define DMAB_RST_CTRL    5'h00

// Sequencer states, one-hot.
`define DMAB_ST_IDLE     3'h1
`define DMAB_ST_READ     3'h2
`define DMAB_ST_WRITE    3'h4

`endif

//--- design/dmab_arbiter.v
// Internal master-bus arbiter between the processor core and the DMA side.
// Assumes one clock; requests come from logic in the same domain.
`timescale 1ns/10ps
`default_nettype none
`include "dmab_regs.vh"

module dmab_arbiter (
	input  wire i_core_clk,
	input  wire i_nrst,
	input  wire i_core_req,
	input  wire i_dma_req,
	input  wire i_bus_idle,
	input  wire i_fetch_killed,
	input  wire i_arbiter_off,
	input  wire i_priority_order_select,
	output reg  o_grant_core,
	output reg  o_grant_dma
);

	reg  killed_q;
	reg  pick_dma;

	// Remember a killed fetch until a bus cycle begins or the channels stop asking.
	// Clearing it on the first idle decision would hand the channels a grant that
	// is gone again before the sequencer can use it.
	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			killed_q <= 1'b0;
		end else if (i_fetch_killed) begin
			killed_q <= 1'b1;
		end else if (!i_bus_idle || !i_dma_req) begin
			killed_q <= 1'b0;
		end
	end

	// Decide the next owner from the priority order and the killed fetch.
	always @* begin
		pick_dma = 1'b0;
		if (i_priority_order_select) begin
			pick_dma = i_dma_req;
		end else begin
			pick_dma = i_dma_req && (!i_core_req || killed_q);
		end
	end

	// Ownership moves only while the bus is between cycles, except that arbiter-off hands it to the core at once.
	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_grant_core <= 1'b1;
			o_grant_dma  <= 1'b0;
		end else if (i_arbiter_off) begin
			o_grant_core <= 1'b1;
			o_grant_dma  <= 1'b0;
		end else if (i_bus_idle) begin
			o_grant_core <= !pick_dma;
			o_grant_dma  <= pick_dma;
		end
	end

endmodule // dmab_arbiter
`default_nettype wire

//--- design/dmab_top.v
// Two-channel DMA count engine with destination, byte count, status flags,
// interrupt and the internal bus arbiter.
// Assumes a simple register port on the core clock and a bus that acknowledges
// each address phase with a one-cycle pulse; all inputs are in this domain.
// Grants reach the top outputs one cycle after the arbiter decides.
`timescale 1ns/10ps
`default_nettype none
`include "dmab_regs.vh"

module dmab_top (
	input  wire        i_core_clk,
	input  wire        i_nrst,
	input  wire [7:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	input  wire        i_core_req,
	input  wire        i_fetch_killed,
	input  wire        i_bus_idle,
	input  wire        i_addr_ack,
	output reg         o_grant_core,
	output reg         o_grant_dma,
	output reg         o_xfer_valid,
	output reg         o_xfer_write,
	output reg         o_xfer_chan,
	output reg  [1:0]  o_xfer_size,
	output reg  [31:0] o_xfer_addr,
	output reg         o_irq
);

	// One-hot sequencer states; a stray code falls back to idle.
	localparam [2:0] ST_IDLE  = `DMAB_ST_IDLE;
	localparam [2:0] ST_READ  = `DMAB_ST_READ;
	localparam [2:0] ST_WRITE = `DMAB_ST_WRITE;

	// Per-channel state, indexed by channel.
	reg  [31:0] dest_addr_q [0:1];
	reg  [15:0] remaining_bytes_q [0:1];
	reg  [4:0]  ctrl_q [0:1];
	reg  [1:0]  busy_q;
	reg  [1:0]  err_hit;
	reg  [1:0]  done_hit;

	// Global control and interrupt state.
	reg         arbiter_off_q;
	reg         priority_order_select_q;
	reg  [3:0]  istat_q;
	reg  [3:0]  imask_q;

	// Sequencer.
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg         cur_q;
	reg         write_done;
	reg  [15:0] dec_amt;

	wire        grant_core;
	wire        grant_dma;
	wire        dma_req;
	wire [3:0]  istat_set;
	wire [3:0]  istat_clr;
	wire        wr_arb;
	wire        wr_imask;
	wire        wr_istat;

	// channel stops on zero or error
	// A stopped channel drops out of the request; a running unit keeps it up.
	assign dma_req = (|busy_q) || (state_q != ST_IDLE);

	assign wr_arb   = i_wr && (i_addr == `DMAB_OFF_ARB);
	assign wr_imask = i_wr && (i_addr == `DMAB_OFF_IMASK);
	assign wr_istat = i_wr && (i_addr == `DMAB_OFF_ISTAT);

	// Interrupt status layout: {err1, done1, err0, done0}.
	assign istat_set = {err_hit[1], done_hit[1], err_hit[0], done_hit[0]};
	assign istat_clr = wr_istat ? i_wdata[3:0] : 4'h0;

	// Decrement for the active channel's size.
	// A line move drops the count by a whole line at one acknowledge.
	always @* begin
		case (ctrl_q[cur_q][`DMAB_CTRL_SIZE_H:`DMAB_CTRL_SIZE_L])
			`DMAB_SZ_BYTE: dec_amt = `DMAB_DEC_BYTE;
			`DMAB_SZ_WORD: dec_amt = `DMAB_DEC_WORD;
			`DMAB_SZ_LINE: dec_amt = `DMAB_DEC_LINE;
			default:       dec_amt = `DMAB_DEC_LONG;
		endcase
	end

	// Bus arbiter; its grants are registered inside.
	// It sees the bus busy from the edge at which the sequencer leaves idle, so
	// only arbiter-off can move ownership under a phase that is just starting.
	dmab_arbiter u_arb (
		.i_core_clk              (i_core_clk),
		.i_nrst                  (i_nrst),
		.i_core_req              (i_core_req),
		.i_dma_req               (dma_req),
		.i_bus_idle              (i_bus_idle && (state_q == ST_IDLE) &&
		                          (state_d == ST_IDLE)),
		.i_fetch_killed          (i_fetch_killed),
		.i_arbiter_off           (arbiter_off_q),
		.i_priority_order_select (priority_order_select_q),
		.o_grant_core            (grant_core),
		.o_grant_dma             (grant_dma)
	);

	// Mirror the grants onto the top outputs.
	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_grant_core <= 1'b1;
			o_grant_dma  <= 1'b0;
		end else begin
			o_grant_core <= grant_core;
			o_grant_dma  <= grant_dma;
		end
	end

	// Next state of the shared transfer sequencer.
	always @* begin
		state_d    = state_q;
		write_done = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// Both grant copies must agree, so the output already shows the owner.
				if (grant_dma && o_grant_dma && busy_q[cur_q]) begin
					if (ctrl_q[cur_q][`DMAB_CTRL_SINGLE] &&
					    ctrl_q[cur_q][`DMAB_CTRL_OFFCHIP]) begin
						state_d = ST_WRITE;
					end else begin
						state_d = ST_READ;
					end
				end
			end
			// A read phase always hands on to the write phase of the same unit.
			ST_READ: begin
				if (i_addr_ack) begin
					state_d = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (i_addr_ack) begin
					write_done = 1'b1;
					state_d    = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Sequencer register and round-robin pick of the next busy channel.
	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			cur_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			// An idle channel is skipped at once, so a lone busy one waits a cycle at most.
			if ((state_q == ST_IDLE) && !busy_q[cur_q]) begin
				cur_q <= !cur_q;
			end else if (write_done) begin
				cur_q <= !cur_q;
			end
		end
	end

	// Bus transfer outputs, all registered.
	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_xfer_valid <= 1'b0;
			o_xfer_write <= 1'b0;
			o_xfer_chan  <= 1'b0;
			o_xfer_size  <= `DMAB_SZ_LONG;
			o_xfer_addr  <= `DMAB_RST_DEST;
		end else begin
			// Request and direction follow the next state so that they change together.
			o_xfer_valid <= (state_d != ST_IDLE);
			o_xfer_write <= (state_d == ST_WRITE);
			if (state_q == ST_IDLE) begin
				o_xfer_chan <= cur_q;
				o_xfer_size <= ctrl_q[cur_q][`DMAB_CTRL_SIZE_H:`DMAB_CTRL_SIZE_L];
			end
			// destination in dual mode only
			// Single-address moves show zero; the far device is reached by its own select.
			if ((state_d == ST_WRITE) && !ctrl_q[cur_q][`DMAB_CTRL_SINGLE]) begin
				o_xfer_addr <= dest_addr_q[cur_q];
			end else begin
				o_xfer_addr <= `DMAB_RST_DEST;
			end
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
			wire [7:0]  base;
			wire        wr_ctrl;
			wire        wr_dest;
			wire        wr_cnt;
			wire        start;
			wire [1:0]  wsize;
			reg         aligned;
			wire        mine;

			assign base    = (ch == 0) ? 8'h00 : `DMAB_CH_STRIDE;
			assign wr_ctrl = i_wr && (i_addr == (base + `DMAB_OFF_CTRL));
			assign wr_dest = i_wr && (i_addr == (base + `DMAB_OFF_DEST));
			assign wr_cnt  = i_wr && (i_addr == (base + `DMAB_OFF_COUNT));
			assign start   = wr_ctrl && i_wdata[`DMAB_CTRL_START] && !busy_q[ch];
			assign wsize   = i_wdata[`DMAB_CTRL_SIZE_H:`DMAB_CTRL_SIZE_L];
			assign mine    = write_done && (cur_q == ch);

			// Alignment of the count against the size being started.
			// The size checked is the one in the starting write, not the stored one.
			always @* begin
				case (wsize)
					`DMAB_SZ_WORD: aligned = ~|(remaining_bytes_q[ch] & `DMAB_ALN_WORD);
					`DMAB_SZ_LONG: aligned = ~|(remaining_bytes_q[ch] & `DMAB_ALN_LONG);
					`DMAB_SZ_LINE: aligned = ~|(remaining_bytes_q[ch] & `DMAB_ALN_LINE);
					default:       aligned = 1'b1;
				endcase
			end

			// Control and destination, writable only while the channel is idle.
			// Writes to a busy channel are dropped so a running block is never retargeted.
			always @(posedge i_core_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					ctrl_q[ch]      <= `DMAB_RST_CTRL;
					dest_addr_q[ch] <= `DMAB_RST_DEST;
				end else begin
					if (wr_ctrl && !busy_q[ch]) begin
						ctrl_q[ch] <= {i_wdata[`DMAB_CTRL_OFFCHIP:`DMAB_CTRL_SIZE_L], 1'b0};
					end
					if (wr_dest && !busy_q[ch]) begin
						dest_addr_q[ch] <= i_wdata;
					end
				end
			end

			always @(posedge i_core_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					remaining_bytes_q[ch] <= `DMAB_RST_COUNT;
				end else if (mine) begin
					remaining_bytes_q[ch] <= remaining_bytes_q[ch] - dec_amt;
				end else if (wr_cnt && !busy_q[ch]) begin
					remaining_bytes_q[ch] <= i_wdata[15:0];
				end
			end

			// Busy and the done/error events of this channel.
			// A start with a zero count completes at once and never asks for the bus.
			always @(posedge i_core_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					busy_q[ch]   <= 1'b0;
					err_hit[ch]  <= 1'b0;
					done_hit[ch] <= 1'b0;
				end else begin
					err_hit[ch]  <= 1'b0;
					done_hit[ch] <= 1'b0;
					if (start) begin
						if (!aligned) begin
							err_hit[ch] <= 1'b1;
						end else if (remaining_bytes_q[ch] == `DMAB_RST_COUNT) begin
							done_hit[ch] <= 1'b1;
						end else begin
							busy_q[ch] <= 1'b1;
						end
					end else if (mine && (remaining_bytes_q[ch] <= dec_amt)) begin
						busy_q[ch]   <= 1'b0;
						done_hit[ch] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// Global arbiter control and interrupt mask.
	// The priority bit takes effect at its next ownership decision; arbiter-off at the next clock edge.
	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			arbiter_off_q           <= 1'b0;
			priority_order_select_q <= 1'b0;
			imask_q                 <= 4'h0;
		end else begin
			if (wr_arb) begin
				arbiter_off_q           <= i_wdata[`DMAB_ARB_OFF];
				priority_order_select_q <= i_wdata[`DMAB_ARB_PRIO];
			end
			if (wr_imask) begin
				imask_q <= i_wdata[3:0];
			end
		end
	end

	// Sticky status; a new event beats a same-cycle write-one clear.
	// The mask only gates the interrupt line; status bits set regardless.
	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			istat_q <= 4'h0;
			o_irq   <= 1'b0;
		end else begin
			istat_q <= (istat_q & ~istat_clr) | istat_set;
			o_irq   <= |(((istat_q & ~istat_clr) | istat_set) & imask_q);
		end
	end

	// Read data appear one cycle after the read strobe; unmapped reads zero.
	// Channel status mirrors the sticky bits, so a write-one clear empties both views.
	always @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			case (i_addr)
				`DMAB_OFF_CTRL: o_rdata <= {27'h0000000, ctrl_q[0]};
				`DMAB_OFF_DEST: o_rdata <= dest_addr_q[0];
				`DMAB_OFF_COUNT: o_rdata <= {16'h0000, remaining_bytes_q[0]};
				`DMAB_OFF_CHSTAT: o_rdata <= {29'h00000000, busy_q[0], istat_q[1:0]};
				`DMAB_CH_STRIDE + `DMAB_OFF_CTRL: o_rdata <= {27'h0000000, ctrl_q[1]};
				`DMAB_CH_STRIDE + `DMAB_OFF_DEST: o_rdata <= dest_addr_q[1];
				`DMAB_CH_STRIDE + `DMAB_OFF_COUNT:
					o_rdata <= {16'h0000, remaining_bytes_q[1]};
				`DMAB_CH_STRIDE + `DMAB_OFF_CHSTAT:
					o_rdata <= {29'h00000000, busy_q[1], istat_q[3:2]};
				`DMAB_OFF_ARB:
					o_rdata <= {30'h00000000, priority_order_select_q, arbiter_off_q};
				`DMAB_OFF_IMASK: o_rdata <= {28'h0000000, imask_q};
				`DMAB_OFF_ISTAT: o_rdata <= {28'h0000000, istat_q};
				default: o_rdata <= 32'h00000000;
			endcase
		end else begin
			o_rdata <= 32'h00000000;
		end
	end

endmodule // dmab_top
`default_nettype wire

//--- verif/dmab_chk_sva.sv
// Port checker for the two-channel DMA count engine and its arbiter.
// Assumes it is bound to dmab_top in one clock domain.
`timescale 1ns/10ps
`default_nettype none
module dmab_chk (
	input wire logic        i_core_clk,
	input wire logic        i_nrst,
	input wire logic        i_rd,
	input wire logic        i_addr_ack,
	input wire logic [31:0] o_rdata,
	input wire logic        o_grant_core,
	input wire logic        o_grant_dma,
	input wire logic        o_xfer_valid,
	input wire logic        o_xfer_write,
	input wire logic        o_xfer_chan,
	input wire logic [1:0]  o_xfer_size,
	input wire logic [31:0] o_xfer_addr
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	// The steps of one transfer unit on the bus.
	sequence s_wait; o_xfer_valid && !i_addr_ack; endsequence
	sequence s_rd_ack; o_xfer_valid && !o_xfer_write && i_addr_ack; endsequence
	sequence s_wr_ack; o_xfer_valid && o_xfer_write && i_addr_ack; endsequence
	grant_excl_a: assert property (!(o_grant_core && o_grant_dma))
		else $error("both masters granted");
	phase_hold_a: assert property (s_wait |=> o_xfer_valid &&
		$stable({o_xfer_write, o_xfer_chan, o_xfer_size, o_xfer_addr}))
		else $error("phase changed before acknowledge");
	dual_order_a: assert property (s_rd_ack |=> o_xfer_valid && o_xfer_write)
		else $error("no write phase after read phase");
	write_end_a: assert property (s_wr_ack |=> !o_xfer_valid)
		else $error("request held after write acknowledge");
	dma_grant_a: assert property (o_xfer_valid |-> o_grant_dma)
		else $error("transfer without bus grant");
	grant_keep_a: assert property (o_xfer_valid |=> o_grant_dma)
		else $error("grant moved during transfer");
	read_addr_a: assert property (o_xfer_valid && !o_xfer_write |-> o_xfer_addr == 32'h0)
		else $error("destination shown in read phase");
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data outside read cycle");
endmodule // dmab_chk
`default_nettype wire

//--- verif/dmab_core_model.sv
// Behavioural core and bus slave sharing the internal master bus.
// Assumes the bench drives the core's wish and the slow-answer choice.
`timescale 1ns/10ps
`default_nettype none
module dmab_core_model (
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	input  wire logic i_slow,
	input  wire logic i_core_want,
	input  wire logic i_xfer_valid,
	output var  logic o_addr_ack,
	output var  logic o_bus_idle,
	output var  logic o_core_req
);
	logic [1:0] wait_q;
	// Core cycles end each clock, so the bus is idle unless a channel phase runs.
	assign o_bus_idle = !i_xfer_valid;
	assign o_core_req = i_core_want;
	// Acknowledges each phase, at once or after a few wait cycles; never two in a row.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_q <= 2'h0;
			o_addr_ack <= 1'b0;
		end else begin
			o_addr_ack <= i_xfer_valid && !o_addr_ack && (!i_slow || wait_q == 2'h3);
			wait_q <= (i_xfer_valid && !o_addr_ack) ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule // dmab_core_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the DMA count engine and bus arbiter.
// Assumes the design, its constants header, the core model and the checker.
`timescale 1ns/10ps
`default_nettype none
`include "dmab_regs.vh"
module tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_q = 1'b0;
	logic        killed = 1'b0;
	logic        slow = 1'b0;
	logic        want = 1'b0;
	logic [31:0] dest_exp = 32'h0;
	logic [2:0]  unit_exp = 3'h0;
	wire logic   ack, idle, creq, gc, gd, xv, xw, xc, irq;
	wire logic [1:0]  xs;
	wire logic [31:0] rdata, xa;
	logic [31:0] exp_q[$];
	int          failures = 0;
	int          tests_run = 0;
	int          acks = 0;
	int          cyc = 0;
	dmab_top u_dmab_top (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_core_req(creq), .i_fetch_killed(killed),
		.i_bus_idle(idle), .i_addr_ack(ack), .o_grant_core(gc), .o_grant_dma(gd),
		.o_xfer_valid(xv), .o_xfer_write(xw), .o_xfer_chan(xc), .o_xfer_size(xs),
		.o_xfer_addr(xa), .o_irq(irq));
	dmab_core_model u_dmab_core_model (.i_core_clk(clk), .i_nrst(nrst), .i_slow(slow),
		.i_core_want(want), .i_xfer_valid(xv), .o_addr_ack(ack), .o_bus_idle(idle),
		.o_core_req(creq));
	// Clock at 125 MHz.
	initial forever #4 clk = ~clk;
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic wait_irq();
		for (int n = 0; n < 600 && irq !== 1'b1; n++)
			@(posedge clk);
	endtask
	// Runs one block on a channel and checks count, flags and interrupt.
	task automatic xfer(input logic [1:0] sz, input int dec, input logic ch, input logic sgl);
		logic [31:0] d;
		logic [15:0] n;
		int a0;
		d = $urandom;
		n = 16'(dec * (1 + $urandom % 4));
		dest_exp = sgl ? 32'h0 : d;
		unit_exp = {ch, sz};
		wr_reg({3'h0, ch, 4'h4}, d);
		wr_reg({3'h0, ch, 4'h8}, {16'h0, n});
		a0 = acks;
		wr_reg({3'h0, ch, 4'h0}, {27'h0, sgl, sgl, sz, 1'b1});
		wait_irq();
		chk(32'(acks - a0), 32'(n) / 32'(dec));
		rd_reg({3'h0, ch, 4'h8}, 32'h0);
		rd_reg(`DMAB_OFF_ISTAT, 32'h1 << (2 * ch));
		wr_reg(`DMAB_OFF_ISTAT, 32'hf);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask
	// Read data is compared in the cycle after each read strobe.
	always @(negedge clk)
		if (rd_q)
			chk(rdata, exp_q.pop_front());
	// Each write phase acknowledge carries the expected destination.
	always @(posedge clk) begin
		rd_q <= rd;
		if (ack && xv && xw) begin
			acks <= acks + 1;
			chk(xa, dest_exp);
			chk({29'h0, xc, xs}, {29'h0, unit_exp});
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end
	initial begin
		int a0;
		void'($urandom(32'hd5e0));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rd_reg(`DMAB_OFF_DEST, 32'h0);
		rd_reg(`DMAB_OFF_COUNT, 32'h0);
		rd_reg(8'h30, 32'h0);
		wr_reg(`DMAB_OFF_IMASK, 32'hf);
		for (int i = 0; i < 8; i++) begin
			slow <= i[0];
			case (i[1:0])
				2'h0: xfer(`DMAB_SZ_BYTE, 1, i[2], i[0]);
				2'h1: xfer(`DMAB_SZ_WORD, 2, i[2], i[0]);
				2'h2: xfer(`DMAB_SZ_LONG, 4, i[2], i[0]);
				default: xfer(`DMAB_SZ_LINE, 16, i[2], i[0]);
			endcase
		end
		// Misaligned counts flag an error with no transfer, interrupt masked off.
		wr_reg(`DMAB_OFF_IMASK, 32'h0);
		for (int s = 1; s < 4; s++) begin
			a0 = acks;
			wr_reg(`DMAB_OFF_COUNT, (s == 3) ? 32'h11 : ((s == 1) ? 32'h3 : 32'h5));
			// The byte code is never misaligned, so the first pass uses the long size.
			wr_reg(`DMAB_OFF_CTRL, {29'h0, ((s == 1) ? `DMAB_SZ_LONG : 2'(s)), 1'b1});
			repeat (6) @(posedge clk);
			chk(32'(acks - a0), 32'h0);
			chk({31'h0, irq}, 32'h0);
			rd_reg(`DMAB_OFF_ISTAT, 32'h2);
			wr_reg(`DMAB_OFF_ISTAT, 32'hf);
		end
		// With arbitration off a started channel never reaches the bus.
		wr_reg(`DMAB_OFF_ARB, 32'h1);
		dest_exp = 32'h0;
		unit_exp = {1'b1, `DMAB_SZ_WORD};
		wr_reg(8'h14, 32'h0);
		wr_reg(8'h18, 32'h4);
		a0 = acks;
		wr_reg(8'h10, {27'h0, 4'h2, 1'b1});
		repeat (40) @(posedge clk);
		chk(32'(acks - a0), 32'h0);
		chk({30'h0, gc, gd}, 32'h2);
		rd_reg(8'h1c, 32'h4);
		// A busy core keeps the bus while it has priority.
		want <= 1'b1;
		wr_reg(`DMAB_OFF_ARB, 32'h0);
		repeat (40) @(posedge clk);
		chk(32'(acks - a0), 32'h0);
		// A killed fetch hands one unit to the channel.
		killed <= 1'b1;
		@(posedge clk);
		killed <= 1'b0;
		repeat (30) @(posedge clk);
		rd_reg(8'h18, 32'h2);
		// Channel priority lets the block finish against the busy core.
		wr_reg(`DMAB_OFF_ARB, 32'h2);
		repeat (60) @(posedge clk);
		rd_reg(8'h18, 32'h0);
		rd_reg(8'h1c, 32'h1);
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule // tb
bind dmab_top dmab_chk u_dmab_chk (.*);
`default_nettype wire
